/* File: hdl/mtm_map.svh */
// Register map, field positions, reset values and encodings for the modulo timer.
// Assumes inclusion by the timer package, the timer top module and the bench.
`ifndef MTM_MAP_SVH
`define MTM_MAP_SVH

// Byte addresses of the 32-bit register words
`define MTM_SC_ADDR 8'h00
`define MTM_CLK_ADDR 8'h04
`define MTM_COUNT_HIGH_ADDR 8'h08
`define MTM_MODULO_HIGH_ADDR 8'h0C
`define MTM_MODULO_LOW_ADDR 8'h10
`define MTM_COUNT_LOW_ADDR 8'h14
`define MTM_CTRL_ADDR 8'h18

// Status and control fields
`define MTM_SC_OVF_BIT 7
`define MTM_SC_IEN_BIT 6
`define MTM_SC_RST_BIT 5
`define MTM_SC_HALT_BIT 4

// Clock select fields
`define MTM_CLK_PS_LSB 0
`define MTM_CLK_SRC_LSB 4

// Control word fields: debug halt and software reset request
`define MTM_CTRL_DBG_BIT 0
`define MTM_CTRL_SWRST_BIT 1

// Reset values and the counter maximum
`define MTM_MOD_RESET 16'h0000
`define MTM_CNT_RESET 16'h0000
`define MTM_PS_RESET 4'h0
`define MTM_CNT_MAX 16'hFFFF

// Clock source encodings
`define MTM_SRC_BUS 2'h0
`define MTM_SRC_FIXED 2'h1
`define MTM_SRC_FALL 2'h2
`define MTM_SRC_RISE 2'h3

// AXI responses
`define MTM_RESP_OKAY 2'h0
`define MTM_RESP_SLVERR 2'h2

`endif

/* File: hdl/mtm_pkg.sv */
// Types shared by the modulo timer.
// Assumes the map header sits beside it.
`include "mtm_map.svh"
package mtm_pkg;
  // Modulo byte latch sequence
  typedef enum logic [2:0] {
    MTM_LAT_IDLE = 3'b001,
    MTM_LAT_HIGH = 3'b010,
    MTM_LAT_LOW = 3'b100
  } mtm_latch_e;
  typedef logic [15:0] mtm_word_t;
endpackage

/* File: hdl/mtm_timer.sv */
// 16-bit modulo timer with prescaler, clock select and AXI4-Lite registers.
// Assumes the fixed clock enable and count pin are synchronous to ref_clk_i.
`timescale 1ns/1ps
`include "mtm_map.svh"
module mtm_timer (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic fixed_freq_clock_i,
  input wire logic ext_count_pin_i,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic overflow_irq_o,
  output mtm_pkg::mtm_word_t count_o
);
  import mtm_pkg::*;

  // Register state
  mtm_word_t count_reg; // Live counter
  mtm_word_t mod_active_reg; // Modulo in effect
  mtm_word_t mod_pending_reg; // Committed, waiting for next overflow or software reset
  logic mod_pending_valid_reg; // Pending value not yet applied
  logic [7:0] buf_high_reg; // Byte latch for the high half
  logic [7:0] buf_low_reg; // Byte latch for the low half
  mtm_latch_e latch_reg; // Which bytes are latched
  logic first_write_reg; // No full modulo write since chip reset
  logic halt_reg; // Counter halt bit
  logic ovf_reg; // Overflow flag
  logic ovf_armed_reg; // Status read seen while flag set
  logic ien_reg; // Overflow interrupt enable
  logic [1:0] src_reg; // Clock source select
  logic [3:0] ps_reg; // Prescale select
  logic debug_halt_mode_reg; // Debug halt mode
  logic pin_prev_reg; // Last sample of count pin
  logic [7:0] prescale_reg; // Prescaler ripple counter

  // Bus handshake state
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;

  // Decoded events
  logic wr_fire;
  logic rd_fire;
  logic wr_sc;
  logic wr_ctrl;
  logic wr_modulo_high;
  logic wr_modulo_low;
  logic trst;
  logic sw_rst;
  logic src_tick;
  logic pre_tick;
  logic wrap;
  logic overflow;
  logic commit;
  mtm_word_t commit_val;
  logic [7:0] wbyte;

  // Write fires when both address and data are held and no response waits
  assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid_o;
  assign rd_fire = s_axi_arvalid_i && s_axi_arready_o;
  assign wbyte = wdata_reg[7:0];
  assign wr_sc = wr_fire && awaddr_reg == `MTM_SC_ADDR && wstrb_reg[0];
  assign wr_ctrl = wr_fire && awaddr_reg == `MTM_CTRL_ADDR && wstrb_reg[0];
  assign wr_modulo_high = wr_fire && awaddr_reg == `MTM_MODULO_HIGH_ADDR && wstrb_reg[0];
  assign wr_modulo_low = wr_fire && awaddr_reg == `MTM_MODULO_LOW_ADDR && wstrb_reg[0];
  assign trst = wr_sc && wbyte[`MTM_SC_RST_BIT];
  assign sw_rst = wr_ctrl && wbyte[`MTM_CTRL_SWRST_BIT];

  // Source edge selection; the pin is taken as already synchronous
  always_comb begin
    case (src_reg)
      `MTM_SRC_BUS: src_tick = 1'b1;
      `MTM_SRC_FIXED: src_tick = fixed_freq_clock_i;
      `MTM_SRC_FALL: src_tick = pin_prev_reg && !ext_count_pin_i;
      default: src_tick = !pin_prev_reg && ext_count_pin_i;
    endcase
  end

  // Prescaler output: a carry out of the selected ripple stage
  always_comb begin
    if (ps_reg[3]) begin
      pre_tick = src_tick && (&prescale_reg);
    end else if (ps_reg == `MTM_PS_RESET) begin
      pre_tick = src_tick;
    end else begin
      pre_tick = src_tick && ((prescale_reg | ~((8'h01 << ps_reg[2:0]) - 8'h01)) == 8'hFF);
    end
  end

  // Wrap at the modulo, or at all-ones when modulo is zero
  assign wrap = (mod_active_reg == `MTM_MOD_RESET) ? (count_reg == `MTM_CNT_MAX)
                                                   : (count_reg == mod_active_reg);
  assign overflow = !halt_reg && pre_tick && wrap;

  // Second byte of a pair completes the commit; frozen while in debug halt
  assign commit = !debug_halt_mode_reg && ((wr_modulo_high && latch_reg == MTM_LAT_LOW) ||
                  (wr_modulo_low && latch_reg == MTM_LAT_HIGH));
  assign commit_val = wr_modulo_high ? {wbyte, buf_low_reg} : {buf_high_reg, wbyte};

  // Pin history for edge detection
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pin_prev_reg <= ext_count_pin_i; // Start at the pin's level: no false edge after reset
    end else begin
      pin_prev_reg <= ext_count_pin_i;
    end
  end

  // Prescaler advances on each source tick while not halted; not cleared by a select change
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || trst) begin
      prescale_reg <= 8'h00;
    end else if (!halt_reg && src_tick) begin
      prescale_reg <= prescale_reg + 8'h01;
    end
  end

  // Byte latch sequence
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || trst) begin
      latch_reg <= MTM_LAT_IDLE;
      buf_high_reg <= 8'h00;
      buf_low_reg <= 8'h00;
    end else if (!debug_halt_mode_reg) begin
      if (commit) begin
        latch_reg <= MTM_LAT_IDLE;
      end else if (wr_modulo_high) begin
        buf_high_reg <= wbyte;
        latch_reg <= MTM_LAT_HIGH;
      end else if (wr_modulo_low) begin
        buf_low_reg <= wbyte;
        latch_reg <= MTM_LAT_LOW;
      end
    end
  end

  // Active and pending modulo, and the counter itself
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mod_active_reg <= `MTM_MOD_RESET;
      mod_pending_reg <= `MTM_MOD_RESET;
      mod_pending_valid_reg <= 1'b0;
      first_write_reg <= 1'b1;
      count_reg <= `MTM_CNT_RESET;
    end else if (debug_halt_mode_reg && (wr_modulo_high || wr_modulo_low)) begin
      if (wr_modulo_high) begin
        mod_active_reg <= {wbyte, mod_active_reg[7:0]};
      end else begin
        mod_active_reg <= {mod_active_reg[15:8], wbyte};
      end
      count_reg <= `MTM_CNT_RESET;
    end else if (commit && first_write_reg) begin
      mod_active_reg <= commit_val;
      first_write_reg <= 1'b0;
      mod_pending_valid_reg <= 1'b0;
      count_reg <= `MTM_CNT_RESET;
    end else if (sw_rst) begin
      if (mod_pending_valid_reg) begin
        mod_active_reg <= mod_pending_reg;
      end
      mod_pending_valid_reg <= 1'b0;
      count_reg <= `MTM_CNT_RESET;
    end else begin
      if (commit) begin
        mod_pending_reg <= commit_val;
        mod_pending_valid_reg <= 1'b1;
      end else if (overflow && mod_pending_valid_reg) begin
        mod_active_reg <= mod_pending_reg;
        mod_pending_valid_reg <= 1'b0;
      end
      if (trst) begin
        count_reg <= `MTM_CNT_RESET;
      end else if (overflow) begin
        count_reg <= `MTM_CNT_RESET;
      end else if (!halt_reg && pre_tick) begin
        count_reg <= count_reg + 16'h0001;
      end
    end
  end

  // Status and control bits
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || sw_rst) begin
      halt_reg <= 1'b1;
      ien_reg <= 1'b0;
    end else if (wr_sc) begin
      halt_reg <= wbyte[`MTM_SC_HALT_BIT];
      ien_reg <= wbyte[`MTM_SC_IEN_BIT];
    end
  end

  // Overflow flag: set wins over the two-step clear
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || sw_rst) begin
      ovf_reg <= 1'b0;
      ovf_armed_reg <= 1'b0;
    end else if (overflow) begin
      ovf_reg <= 1'b1;
      ovf_armed_reg <= 1'b0;
    end else if (trst) begin
      ovf_reg <= 1'b0;
      ovf_armed_reg <= 1'b0;
    end else if (wr_sc && !wbyte[`MTM_SC_OVF_BIT] && ovf_armed_reg) begin
      ovf_reg <= 1'b0;
      ovf_armed_reg <= 1'b0;
    end else if (rd_fire && s_axi_araddr_i == `MTM_SC_ADDR && ovf_reg) begin
      ovf_armed_reg <= 1'b1;
    end
  end

  // Clock select and debug halt controls
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      src_reg <= `MTM_SRC_BUS;
      ps_reg <= `MTM_PS_RESET;
      debug_halt_mode_reg <= 1'b0;
    end else begin
      if (wr_fire && awaddr_reg == `MTM_CLK_ADDR && wstrb_reg[0]) begin
        src_reg <= wbyte[`MTM_CLK_SRC_LSB +: 2];
        ps_reg <= wbyte[`MTM_CLK_PS_LSB +: 4];
      end
      if (wr_ctrl) begin
        debug_halt_mode_reg <= wbyte[`MTM_CTRL_DBG_BIT];
      end
    end
  end

  // Interrupt request and counter view, both registered
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      overflow_irq_o <= 1'b0;
      count_o <= `MTM_CNT_RESET;
    end else begin
      overflow_irq_o <= ovf_reg && ien_reg;
      count_o <= count_reg;
    end
  end

  // Write channels: take address and data in either order
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `MTM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        // Unmapped or counter addresses answer with a slave error
        if (awaddr_reg == `MTM_SC_ADDR || awaddr_reg == `MTM_CLK_ADDR ||
            awaddr_reg == `MTM_MODULO_HIGH_ADDR || awaddr_reg == `MTM_MODULO_LOW_ADDR ||
            awaddr_reg == `MTM_CTRL_ADDR) begin
          s_axi_bresp_o <= `MTM_RESP_OKAY;
        end else begin
          s_axi_bresp_o <= `MTM_RESP_SLVERR;
        end
      end else if (s_axi_bvalid_o && s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Ready outputs are registered: open only while the slot is empty
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_arready_o <= 1'b0;
    end else begin
      s_axi_awready_o <= !aw_held_reg && !(s_axi_awvalid_i && s_axi_awready_o) &&
                         !s_axi_bvalid_o && !wr_fire;
      s_axi_wready_o <= !w_held_reg && !(s_axi_wvalid_i && s_axi_wready_o) &&
                        !s_axi_bvalid_o && !wr_fire;
      s_axi_arready_o <= !s_axi_rvalid_o && !rd_fire;
    end
  end

  // Read channel: one cycle after the address is taken
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `MTM_RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o <= `MTM_RESP_OKAY;
      case (s_axi_araddr_i)
        `MTM_SC_ADDR: s_axi_rdata_o <= {24'h000000, ovf_reg, ien_reg, 1'b0, halt_reg, 4'h0};
        `MTM_CLK_ADDR: s_axi_rdata_o <= {24'h000000, 2'h0, src_reg, ps_reg};
        `MTM_COUNT_HIGH_ADDR: s_axi_rdata_o <= {24'h000000, count_reg[15:8]};
        `MTM_COUNT_LOW_ADDR: s_axi_rdata_o <= {24'h000000, count_reg[7:0]};
        `MTM_MODULO_HIGH_ADDR: s_axi_rdata_o <= {24'h000000, mod_active_reg[15:8]};
        `MTM_MODULO_LOW_ADDR: s_axi_rdata_o <= {24'h000000, mod_active_reg[7:0]};
        `MTM_CTRL_ADDR: s_axi_rdata_o <= {30'h00000000, 1'b0, debug_halt_mode_reg};
        default: begin
          s_axi_rdata_o <= 32'h0000_0000;
          s_axi_rresp_o <= `MTM_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule

/* File: test/mtm_timer_asserts.sv */
// Port-level checks for the modulo timer.
// Assumes it is bound to mtm_timer and sees only its ports.
`timescale 1ns/1ps
module mtm_timer_asserts (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic overflow_irq_o,
  input wire mtm_pkg::mtm_word_t count_o
);
  import mtm_pkg::*;
  // One clock domain, so one default clock and reset
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  AST_RST_ZERO: assert property ($past(rst_i) |-> count_o == 16'h0000 && !overflow_irq_o)
    else $error("count or irq not clear after reset");
  // Count only steps by one or restarts at zero
  AST_STEP: assert property (count_o != $past(count_o) |->
    count_o == $past(count_o) + 16'h0001 || count_o == 16'h0000)
    else $error("count moved by other than one");
  AST_WRAP: assert property ($past(count_o) == 16'hFFFF |-> count_o inside {16'hFFFF, 16'h0000})
    else $error("all-ones count did not wrap to zero");
  // Slack of three counts on the irq covers its register stage
  AST_IRQ_OVF: assert property ($rose(overflow_irq_o) |-> count_o <= 16'h0003)
    else $error("irq rose away from an overflow");
  AST_B_ANS: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
    && s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o)
    else $error("write response late");
  AST_R_ANS: assert property (s_axi_arvalid_i && s_axi_arready_o |-> ##[1:2] s_axi_rvalid_o)
    else $error("read data late");
  AST_B_HOLD: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped early");
  AST_AW_BUSY: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  // Main scenarios
  COV_IRQ: cover property ($rose(overflow_irq_o));
  COV_WRAP: cover property ($past(count_o) == 16'hFFFF && count_o == 16'h0000);
  COV_RD: cover property (s_axi_rvalid_o && s_axi_rready_i);
endmodule
bind mtm_timer mtm_timer_asserts i_mtm_timer_asserts (.ref_clk_i, .rst_i, .s_axi_awvalid_i,
  .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
  .s_axi_bready_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
  .s_axi_rready_i, .overflow_irq_o, .count_o);

/* File: test/mtm_timer_tb.sv */
// Directed bench for the modulo timer over its AXI4-Lite port.
// Assumes the timer package and map header are compiled alongside.
`timescale 1ns/1ps
`include "mtm_map.svh"
module mtm_timer_tb;
  import mtm_pkg::*;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic fixed_freq_clock_i = 1'b0;
  logic ext_count_pin_i = 1'b0;
  logic [7:0] s_axi_awaddr_i = 8'h00;
  logic s_axi_awvalid_i = 1'b0;
  logic s_axi_awready_o;
  logic [31:0] s_axi_wdata_i = 32'h00000000;
  logic [3:0] s_axi_wstrb_i = 4'h1; // Only lane 0 carries register bits
  logic s_axi_wvalid_i = 1'b0;
  logic s_axi_wready_o;
  logic [1:0] s_axi_bresp_o;
  logic s_axi_bvalid_o;
  logic s_axi_bready_i = 1'b0;
  logic [7:0] s_axi_araddr_i = 8'h00;
  logic s_axi_arvalid_i = 1'b0;
  logic s_axi_arready_o;
  logic [31:0] s_axi_rdata_o;
  logic [1:0] s_axi_rresp_o;
  logic s_axi_rvalid_o;
  logic s_axi_rready_i = 1'b0;
  logic overflow_irq_o;
  mtm_word_t count_o;
  int err_count = 0;
  int samples_checked = 0;
  int cyc = 0; // Free cycle count behind the slow sources
  logic [31:0] rv; // Last read data
  logic [1:0] rr; // Last read response
  logic [1:0] wb; // Last write response
  mtm_word_t c0;
  // Clock settings under test, with count period in bus cycles
  logic [7:0] cb [7] = '{8'h00, 8'h02, 8'h08, 8'h09, 8'h10, 8'h20, 8'h30};
  int per [7] = '{1, 4, 256, 256, 4, 8, 8};
  mtm_timer i_mtm_timer (.ref_clk_i, .rst_i, .fixed_freq_clock_i, .ext_count_pin_i,
    .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i,
    .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o,
    .s_axi_rvalid_o, .s_axi_rready_i, .overflow_irq_o, .count_o);
  // 100 MHz bus clock
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  // Tick every 4 cycles, pin edges every 4 (each edge kind every 8)
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    fixed_freq_clock_i <= (cyc[1:0] == 2'h3);
    ext_count_pin_i <= cyc[2];
  end
  // Verdict and end of run
  task automatic results;
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // A wait that ran out counts as a mismatch
  task automatic tmo;
    err_count++;
    results();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h000000, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_awready_o === 1'b1) s_axi_awvalid_i <= 1'b0;
      if (s_axi_wready_o === 1'b1) s_axi_wvalid_i <= 1'b0;
      // Ready follows the answer by a cycle, so the hold checks see a stall
      if (s_axi_bvalid_o === 1'b1 && s_axi_bready_i !== 1'b1) s_axi_bready_i <= 1'b1;
      if (n > 99) tmo();
    end while (!(s_axi_bvalid_o === 1'b1 && s_axi_bready_i === 1'b1));
    wb = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask
  // Read: data and response taken at the handshake edge, a cycle after rvalid is seen
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (s_axi_arready_o === 1'b1) s_axi_arvalid_i <= 1'b0;
      // Ready follows the data by a cycle, so the hold checks see a stall
      if (s_axi_rvalid_o === 1'b1 && s_axi_rready_i !== 1'b1) s_axi_rready_i <= 1'b1;
      if (n > 99) tmo();
    end while (!(s_axi_rvalid_o === 1'b1 && s_axi_rready_i === 1'b1));
    rv = s_axi_rdata_o;
    rr = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(rv, {24'h000000, e});
  endtask
  // Bounded wait for a count value
  task automatic waitc(input mtm_word_t v);
    int n;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (n > 70000) tmo();
    end while (count_o !== v);
  endtask
  // Align to a count step so later spans are exact
  task automatic sync;
    mtm_word_t p;
    int n;
    p = count_o;
    n = 0;
    do begin
      @(posedge ref_clk_i);
      n++;
      if (n > 600) tmo();
    end while (count_o === p);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rdc(`MTM_SC_ADDR, 8'h10);
    rdc(`MTM_CLK_ADDR, 8'h00);
    rdc(`MTM_MODULO_HIGH_ADDR, 8'h00);
    rdc(`MTM_MODULO_LOW_ADDR, 8'h00);
    chk({16'h0000, count_o}, 32'h00000000);
    rd(8'h1C);
    chk({30'h0, rr}, {30'h0, `MTM_RESP_SLVERR});
    // The count is read-only: a write is refused and leaves it alone
    wr(`MTM_COUNT_HIGH_ADDR, 8'h55);
    chk({30'h0, wb}, {30'h0, `MTM_RESP_SLVERR});
    chk({16'h0000, count_o}, 32'h00000000);
    $display("test reset done");
    wr(`MTM_SC_ADDR, 8'h00);
    chk({30'h0, wb}, {30'h0, `MTM_RESP_OKAY});
    for (int i = 0; i < 7; i++) begin
      c0 = count_o;
      wr(`MTM_CLK_ADDR, cb[i]);
      chk({31'h0, count_o < c0}, 32'h00000000);
      sync();
      c0 = count_o;
      repeat (per[i] * 3) @(posedge ref_clk_i);
      chk({16'h0000, count_o}, {16'h0000, c0 + 16'h0003});
    end
    $display("test clocking done");
    wr(`MTM_SC_ADDR, 8'h10);
    wr(`MTM_CLK_ADDR, 8'h00);
    wr(`MTM_MODULO_HIGH_ADDR, 8'h00);
    wr(`MTM_MODULO_LOW_ADDR, 8'h05);
    rdc(`MTM_MODULO_LOW_ADDR, 8'h05);
    chk({16'h0000, count_o}, 32'h00000000);
    wr(`MTM_SC_ADDR, 8'h00);
    waitc(16'h0005);
    @(posedge ref_clk_i);
    chk({16'h0000, count_o}, 32'h00000000);
    rdc(`MTM_SC_ADDR, 8'h80);
    // Arm the clear while halted, let an overflow in, then try the clear
    wr(`MTM_SC_ADDR, 8'h90);
    rdc(`MTM_SC_ADDR, 8'h90);
    wr(`MTM_SC_ADDR, 8'h80);
    repeat (10) @(posedge ref_clk_i);
    wr(`MTM_SC_ADDR, 8'h10);
    rdc(`MTM_SC_ADDR, 8'h90);
    wr(`MTM_SC_ADDR, 8'h10);
    wr(`MTM_MODULO_HIGH_ADDR, 8'h00);
    wr(`MTM_MODULO_LOW_ADDR, 8'h0A);
    rdc(`MTM_MODULO_LOW_ADDR, 8'h05);
    wr(`MTM_SC_ADDR, 8'h00);
    waitc(16'h000A);
    wr(`MTM_MODULO_LOW_ADDR, 8'h07);
    repeat (30) @(posedge ref_clk_i);
    rdc(`MTM_MODULO_LOW_ADDR, 8'h0A);
    // Halt first, keeping the flag, so no overflow lands on the counter reset
    wr(`MTM_SC_ADDR, 8'h90);
    wr(`MTM_SC_ADDR, 8'h30);
    rdc(`MTM_SC_ADDR, 8'h10);
    wr(`MTM_MODULO_HIGH_ADDR, 8'h00);
    wr(`MTM_CTRL_ADDR, 8'h02);
    rdc(`MTM_MODULO_LOW_ADDR, 8'h0A);
    wr(`MTM_SC_ADDR, 8'h30);
    wr(`MTM_MODULO_HIGH_ADDR, 8'h00);
    wr(`MTM_MODULO_LOW_ADDR, 8'h03);
    rdc(`MTM_MODULO_LOW_ADDR, 8'h0A);
    wr(`MTM_CTRL_ADDR, 8'h02);
    rdc(`MTM_MODULO_LOW_ADDR, 8'h03);
    $display("test modulo done");
    wr(`MTM_MODULO_HIGH_ADDR, 8'h00);
    wr(`MTM_CTRL_ADDR, 8'h01);
    wr(`MTM_MODULO_LOW_ADDR, 8'h09);
    rdc(`MTM_MODULO_LOW_ADDR, 8'h09);
    wr(`MTM_CTRL_ADDR, 8'h00);
    wr(`MTM_MODULO_LOW_ADDR, 8'h04);
    wr(`MTM_CTRL_ADDR, 8'h02);
    rdc(`MTM_MODULO_LOW_ADDR, 8'h04);
    $display("test debug done");
    wr(`MTM_SC_ADDR, 8'h40);
    waitc(16'h0004);
    repeat (4) @(posedge ref_clk_i);
    chk({31'h0, overflow_irq_o}, 32'h00000001);
    wr(`MTM_SC_ADDR, 8'h50);
    rdc(`MTM_SC_ADDR, 8'hD0);
    wr(`MTM_SC_ADDR, 8'h50);
    rdc(`MTM_SC_ADDR, 8'h50);
    chk({31'h0, overflow_irq_o}, 32'h00000000);
    $display("test flag done");
    wr(`MTM_CTRL_ADDR, 8'h01);
    wr(`MTM_MODULO_LOW_ADDR, 8'h00);
    wr(`MTM_CTRL_ADDR, 8'h00);
    wr(`MTM_SC_ADDR, 8'h00);
    waitc(16'hFFFF);
    @(posedge ref_clk_i);
    chk({16'h0000, count_o}, 32'h00000000);
    rdc(`MTM_SC_ADDR, 8'h80);
    $display("test wrap done");
    results();
  end
endmodule
